// File: vfd_pkg.sv
package vfd_pkg;

	// Register byte offsets on the AHB-Lite slave
	localparam logic [11:0] VFD_OFF_BANK = 12'h0004;
	localparam logic [11:0] VFD_OFF_CTRL = 12'h0028;
	localparam logic [11:0] VFD_OFF_PTR = 12'h002C;
	localparam logic [11:0] VFD_OFF_IND = 12'h0030;
	// Direct data memory window: byte address = base + 4 * memory address
	localparam logic [1:0] VFD_DIR_TAG = 2'h2;

	// Display storage span in data memory
	localparam logic [7:0] VFD_MEM_LO = 8'h40;
	localparam logic [7:0] VFD_MEM_HI = 8'h55;
	localparam int VFD_MEM_BYTES = 22;
	localparam logic [7:0] VFD_BANK_DISP = 8'h01;

	// Control register fields and reset value
	localparam int VFD_MODE_LSB = 0;
	localparam int VFD_EN_BIT = 4;
	localparam int VFD_DIM_LSB = 5;
	localparam logic [7:0] VFD_CTRL_RESET = 8'h07;
	localparam logic [7:0] VFD_CTRL_WMASK = 8'hF7;

	// Scan geometry
	localparam int VFD_GRIDS = 11;
	localparam int VFD_SEGS = 16;
	localparam int VFD_GRID_BASE = 4;
	localparam logic [3:0] VFD_LAST_PHASE = 4'hF;
	localparam logic [1:0] VFD_PRE_LAST = 2'h3;
	localparam int VFD_DIV_BITS = 7;

	// AHB-Lite constants
	localparam logic [1:0] VFD_HRESP_OKAY = 2'h0;

	// Configuration-time options, fixed at build of the chip
	typedef struct packed {
		logic src_rtc;
		logic [2:0] div_sel;
		logic halt_keep;
	} vfd_opt_t;

	// Drive outputs toward the display
	typedef struct packed {
		logic [VFD_GRIDS-1:0] grid;
		logic [VFD_SEGS-1:0] seg;
	} vfd_drive_t;

endpackage

// File: vfd_pin_sync.sv
`timescale 1ns/100ps
// Three-stage synchroniser with agreement filter and rising-edge pulse
module vfd_pin_sync (
	input wire logic clk,
	input wire logic resetn,
	input wire logic pin_in,
	output logic rise_pulse
);
	typedef struct packed {
		logic [2:0] sync;
		logic level;
		logic rise;
	} vfd_sync_t;

	vfd_sync_t st_reg;
	vfd_sync_t st_next;

	// Level follows the pin only when stages two and three agree
	always_comb begin
		st_next = st_reg;
		st_next.sync = {st_reg.sync[1:0], pin_in};
		st_next.rise = 1'b0;
		if (st_reg.sync[1] == st_reg.sync[2]) begin
			st_next.level = st_reg.sync[2];
			st_next.rise = st_reg.sync[2] & ~st_reg.level;
		end
	end

	// State register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rise_pulse = st_reg.rise;
endmodule

// File: vfd_tick_div.sv
`timescale 1ns/100ps
// Power-of-two divider of a tick stream, ratio 2**sel
module vfd_tick_div (
	input wire logic clk,
	input wire logic resetn,
	input wire logic tick_in,
	input wire logic [2:0] sel,
	output logic tick_out
);
	typedef struct packed {
		logic [vfd_pkg::VFD_DIV_BITS-1:0] cnt;
	} vfd_div_t;

	vfd_div_t st_reg;
	vfd_div_t st_next;
	logic [vfd_pkg::VFD_DIV_BITS-1:0] mask;

	// Mask of counter bits that must all be ones
	always_comb begin
		mask = ~({vfd_pkg::VFD_DIV_BITS{1'b1}} << sel);
		st_next = st_reg;
		if (tick_in) begin
			st_next.cnt = st_reg.cnt + 1'b1;
		end
	end

	// Counter register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick_out = tick_in & ((st_reg.cnt & mask) == mask);
endmodule

// File: vfd_display_control.sv
`timescale 1ns/100ps
// Functional notes
// - 22 display bytes at 40H-55H, bank one
// - Bank pointer one selects display, zero general
// - Display storage reached only through indirect pointer
// - Driver fetches display bytes without processor
// - One bit per segment per grid, one lights
// - Grid n uses bytes 40H+2n and 41H+2n
// - Mode field selects grid and segment counts
// - Control bit 4 enables display driving
// - Dimming field sets pulse width per slot
// - Control bit 3 always reads zero
// - Reset: 11 grids, 11 segments, 1/16, off
// - Source is RTC oscillator or system clock/4
// - Further divide by one to 128
// - Runs in halt only with option and RTC
module vfd_display_control (
	// System clock and asynchronous reset
	input wire logic clk,
	input wire logic resetn,
	// AHB-Lite slave port
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic [1:0] hresp,
	// Build options and chip state
	input wire vfd_pkg::vfd_opt_t options,
	input wire logic halt,
	input wire logic rtc_osc,
	// Display drive, high active
	output logic [vfd_pkg::VFD_GRIDS-1:0] grid_outputs,
	output logic [vfd_pkg::VFD_SEGS-1:0] segment_outputs
);
	// Whole state of the block
	// One register holds it all but the synchroniser and divider flops; the next value comes from one process
	typedef struct packed {
		// Display control register image
		logic [7:0] ctrl;
		// Bank pointer; one routes the span to display storage
		logic [7:0] bank;
		// Indirect memory pointer
		logic [7:0] ptr;
		// Display storage bytes, index 0 is the lowest span address
		logic [vfd_pkg::VFD_MEM_BYTES-1:0][7:0] disp;
		// General purpose bytes that share the span addresses
		logic [vfd_pkg::VFD_MEM_BYTES-1:0][7:0] gen;
		// Write data phase follows next cycle
		logic wr_pend;
		// Address captured for that data phase
		logic [11:0] wr_addr;
		// Read data held until the next read
		logic [31:0] rdata;
		// Divide-by-four prescaler of the system clock
		logic [1:0] pre;
		// Sixteenth of the current grid slot
		logic [3:0] phase;
		// Grid now being scanned
		logic [3:0] grid;
		// Segment bits fetched for that grid
		logic [15:0] word;
		// Registered drive toward the pins
		vfd_pkg::vfd_drive_t drive;
	} vfd_state_t;

	vfd_state_t st_reg;
	vfd_state_t st_next;

	// Tick chain signals
	// Filtered rising edge of the oscillator pin
	logic rtc_rise;
	// Selected source tick, before the option divider
	logic src_tick;
	// Tick that steps the scan phase
	logic drv_tick;
	// Scan allowed by enable and halt state
	logic running;

	// Bus request qualification
	// Read address phase on the bus, ready or not
	logic req_rd;
	// Address phase taken at this edge
	logic accept;

	// Decoded control fields
	// Grid and segment mode
	logic [2:0] mode;
	// Dimming code
	logic [2:0] dim;
	// Display drive enable bit
	logic enable;
	// Number of grids in the scan
	logic [3:0] grid_count;
	// Lit phases per slot
	logic [3:0] width;
	// Segments used in this mode
	logic [15:0] seg_mask;

	// RTC oscillator pin into the system clock domain
	// Three flops and an agreement filter reject one-clock glitches on the pin
	vfd_pin_sync u_rtc_sync (
		.clk(clk),
		.resetn(resetn),
		.pin_in(rtc_osc),
		.rise_pulse(rtc_rise)
	);

	// Source select: RTC edges or every fourth system clock
	// The pin edge arrives a few clocks late through the synchroniser,
	// which only shifts the scan and never changes its rate
	always_comb begin
		if (options.src_rtc) begin
			src_tick = rtc_rise;
		end else begin
			src_tick = (st_reg.pre == vfd_pkg::VFD_PRE_LAST);
		end
	end

	// Option divider between source and scan logic
	// The divider passes one source tick in every two to the power of the option
	vfd_tick_div u_div (
		.clk(clk),
		.resetn(resetn),
		.tick_in(src_tick),
		.sel(options.div_sel),
		.tick_out(drv_tick)
	);

	// Field decode of the control register
	// Fields are read from the stored value, so a write shows
	// its effect from the cycle after its data phase
	always_comb begin
		// Raw fields
		mode = st_reg.ctrl[vfd_pkg::VFD_MODE_LSB +: 3];
		dim = st_reg.ctrl[vfd_pkg::VFD_DIM_LSB +: 3];
		enable = st_reg.ctrl[vfd_pkg::VFD_EN_BIT];
		// Grid count is mode plus four
		// giving four to eleven grids
		grid_count = 4'(vfd_pkg::VFD_GRID_BASE) + {1'b0, mode};
		// Segment count per mode; unused high segments stay dark
		// Modes below three use all sixteen segments
		case (mode)
			3'h3: seg_mask = 16'h7FFF;
			3'h4: seg_mask = 16'h3FFF;
			3'h5: seg_mask = 16'h1FFF;
			3'h6: seg_mask = 16'h0FFF;
			3'h7: seg_mask = 16'h07FF;
			default: seg_mask = 16'hFFFF;
		endcase
		// Lit phases out of sixteen per grid slot
		// Codes above two jump to wide pulses
		case (dim)
			3'h0: width = 4'h1;
			3'h1: width = 4'h2;
			3'h2: width = 4'h4;
			3'h3: width = 4'hA;
			3'h4: width = 4'hB;
			3'h5: width = 4'hC;
			3'h6: width = 4'hD;
			3'h7: width = 4'hE;
			default: width = 4'h1;
		endcase
	end

	// Driving runs when enabled and halt permits it
	// Halt keeps the scan only on the oscillator, as the system clock stops
	assign running = enable & (~halt | (options.halt_keep & options.src_rtc));

	// Read stalls one cycle behind a pending write so it sees the new value
	// Read request on the bus
	assign req_rd = hsel & htrans[1] & ~hwrite;
	// Wait state only for a read against a pending write
	assign hreadyout = ~(st_reg.wr_pend & req_rd);
	// Transfers are taken only while the bus is ready
	assign accept = hsel & htrans[1] & hready;
	// Every transfer ends OKAY, unmapped ones included
	assign hresp = vfd_pkg::VFD_HRESP_OKAY;
	// Read data straight from its register
	assign hrdata = st_reg.rdata;

	// True when a data memory address lies in the display span
	// Addresses outside the span never select either store
	function automatic logic in_span(input logic [7:0] a);
		in_span = (a >= vfd_pkg::VFD_MEM_LO) && (a <= vfd_pkg::VFD_MEM_HI);
	endfunction

	// Byte index inside the display span
	// Only valid when the address lies in the span
	function automatic logic [4:0] span_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - vfd_pkg::VFD_MEM_LO;
		span_idx = d[4:0];
	endfunction

	// Register read value for a bus address
	function automatic logic [31:0] bus_read(input vfd_state_t s, input logic [11:0] a);
		logic [7:0] m;
		// Unmapped addresses read as zero
		bus_read = 32'h0000_0000;
		m = a[9:2];
		if (a == vfd_pkg::VFD_OFF_BANK) begin
			// Bank pointer reads back as written
			bus_read = {24'h00_0000, s.bank};
		end else if (a == vfd_pkg::VFD_OFF_CTRL) begin
			bus_read = {24'h00_0000, s.ctrl & vfd_pkg::VFD_CTRL_WMASK};
		end else if (a == vfd_pkg::VFD_OFF_PTR) begin
			// Pointer reads back as written
			bus_read = {24'h00_0000, s.ptr};
		end else if (a == vfd_pkg::VFD_OFF_IND) begin
			// Indirect access picks display or general bytes by bank
			// A pointer outside the span reads zero
			if (in_span(s.ptr)) begin
				if (s.bank == vfd_pkg::VFD_BANK_DISP) begin
					bus_read = {24'h00_0000, s.disp[span_idx(s.ptr)]};
				end else begin
					bus_read = {24'h00_0000, s.gen[span_idx(s.ptr)]};
				end
			end
		end else if (a[11:10] == vfd_pkg::VFD_DIR_TAG) begin
			// Direct addressing only ever reaches general memory
			// so display storage stays out of reach of plain moves
			if (in_span(m)) begin
				bus_read = {24'h00_0000, s.gen[span_idx(m)]};
			end
		end
	endfunction

	// Next state
	always_comb begin
		logic [7:0] wb;
		logic [7:0] dm;
		logic [4:0] lo_idx;
		logic [3:0] nxt_grid;
		// Only the low byte of the write data is used
		wb = hwdata[7:0];
		// Data memory address of a direct write
		dm = st_reg.wr_addr[9:2];
		lo_idx = 5'h00;
		nxt_grid = 4'h0;
		st_next = st_reg;

		// System clock prescaler for the divided source
		st_next.pre = st_reg.pre + 2'h1;

		// Write data phase
		// The register picked in the address phase takes the byte now
		if (st_reg.wr_pend) begin
			if (st_reg.wr_addr == vfd_pkg::VFD_OFF_BANK) begin
				// Bank pointer
				st_next.bank = wb;
			end else if (st_reg.wr_addr == vfd_pkg::VFD_OFF_CTRL) begin
				// Control, bit three dropped
				st_next.ctrl = wb & vfd_pkg::VFD_CTRL_WMASK;
			end else if (st_reg.wr_addr == vfd_pkg::VFD_OFF_PTR) begin
				// Indirect pointer
				st_next.ptr = wb;
			end else if (st_reg.wr_addr == vfd_pkg::VFD_OFF_IND) begin
				// Indirect write lands in display storage only in bank one
				if (in_span(st_reg.ptr)) begin
					if (st_reg.bank == vfd_pkg::VFD_BANK_DISP) begin
						st_next.disp[span_idx(st_reg.ptr)] = wb;
					end else begin
						st_next.gen[span_idx(st_reg.ptr)] = wb;
					end
				end
			end else if (st_reg.wr_addr[11:10] == vfd_pkg::VFD_DIR_TAG) begin
				// Direct write cannot touch display storage
				// even while the bank pointer is one
				if (in_span(dm)) begin
					st_next.gen[span_idx(dm)] = wb;
				end
			end
		end

		// Address phase capture
		// A read is never taken while a write is pending, see the stall
		if (accept) begin
			st_next.wr_pend = hwrite;
			st_next.wr_addr = haddr[11:0];
			if (!hwrite) begin
				st_next.rdata = bus_read(st_reg, haddr[11:0]);
			end
		end else if (st_reg.wr_pend) begin
			st_next.wr_pend = 1'b0;
		end

		// Scan sequencer
		// Phase counts sixteenths of a slot; the grid steps at phase fifteen
		if (!enable) begin
			// Idle: park on grid zero with its bytes preloaded
			// so the first slot after enable shows the right segments
			st_next.phase = 4'h0;
			st_next.grid = 4'h0;
			st_next.word = {st_reg.disp[1], st_reg.disp[0]};
		end else if (running && drv_tick) begin
			// One phase per driver tick
			st_next.phase = st_reg.phase + 4'h1;
			if (st_reg.phase == vfd_pkg::VFD_LAST_PHASE) begin
				// Advance to the next grid and fetch its two bytes
				// Memory updates made mid-slot appear from the next slot
				if (st_reg.grid + 4'h1 >= grid_count) begin
					nxt_grid = 4'h0;
				end else begin
					nxt_grid = st_reg.grid + 4'h1;
				end
				st_next.grid = nxt_grid;
				// Low byte of grid n sits at twice n in the span
				lo_idx = 5'({nxt_grid, 1'b0});
				st_next.word = {st_reg.disp[lo_idx + 5'h01], st_reg.disp[lo_idx]};
			end
		end

		// Drive outputs: active grid and its segments while in the lit part
		// Cleared every cycle so a halt or disable blanks the pins at the next clock edge
		st_next.drive = '0;
		if (running && (st_reg.phase < width)) begin
			st_next.drive.grid = {{(vfd_pkg::VFD_GRIDS-1){1'b0}}, 1'b1} << st_reg.grid;
			st_next.drive.seg = st_reg.word & seg_mask;
		end
	end

	// State register; control comes up as 11/11, 1/16, disabled
	// All other state, memories included, clears to zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
			st_reg.ctrl <= vfd_pkg::VFD_CTRL_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// Drive pins come straight from the state flip-flops
	// so they never glitch between grids
	assign grid_outputs = st_reg.drive.grid;
	assign segment_outputs = st_reg.drive.seg;
endmodule

// File: vfd_chk_checker.sv
`timescale 1ns/100ps
module vfd_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic [1:0] hresp,
	input wire logic [vfd_pkg::VFD_GRIDS-1:0] grid_outputs,
	input wire logic [vfd_pkg::VFD_SEGS-1:0] segment_outputs
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Read accepted this cycle, and read of the control word
	logic rd_acc;
	logic ctrl_rd;
	assign rd_acc = hsel && htrans[1] && hready && !hwrite;
	assign ctrl_rd = rd_acc && haddr[11:0] == vfd_pkg::VFD_OFF_CTRL;
	okay_resp_a: assert property (hresp == vfd_pkg::VFD_HRESP_OKAY)
		else $error("response not okay");
	one_wait_a: assert property (!hreadyout |=> hreadyout)
		else $error("wait longer than one cycle");
	wait_cause_a: assert property (!hreadyout |-> hsel && htrans[1] && !hwrite)
		else $error("wait without a read");
	ctrl_bit3_a: assert property (ctrl_rd |=> hrdata[3] == 1'b0)
		else $error("control bit 3 read high");
	upper_zero_a: assert property (hrdata[31:8] == 24'h00_0000)
		else $error("read data above byte");
	rd_hold_a: assert property ($changed(hrdata) |-> $past(rd_acc))
		else $error("read data moved without read");
	grid_onehot_a: assert property ($onehot0(grid_outputs))
		else $error("more than one grid");
	grid_gap_a: assert property (grid_outputs != 0 && $changed(grid_outputs) |-> $past(grid_outputs) == 0)
		else $error("grid switched without dark gap");
	// Main scenarios
	cover property (grid_outputs[vfd_pkg::VFD_GRIDS-1]);
	cover property (!hreadyout);
	cover property (segment_outputs[vfd_pkg::VFD_SEGS-1] && grid_outputs[0]);
endmodule
bind vfd_display_control vfd_chk vfd_chk_inst (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
	.hresp(hresp), .grid_outputs(grid_outputs), .segment_outputs(segment_outputs));

// File: vfd_panel.sv
`timescale 1ns/100ps
// Display tube model: notes which grids lit and what grid 0 showed
module vfd_panel (
	input wire logic clk,
	input wire logic clr,
	input wire logic [vfd_pkg::VFD_GRIDS-1:0] grid,
	input wire logic [vfd_pkg::VFD_SEGS-1:0] seg,
	output logic [vfd_pkg::VFD_GRIDS-1:0] grid_union,
	output logic [vfd_pkg::VFD_SEGS-1:0] seg_first,
	output logic [15:0] lit_first
);
	// Accumulate over a measuring window
	always_ff @(posedge clk) begin
		if (clr) begin
			grid_union <= '0;
			seg_first <= '0;
			lit_first <= '0;
		end else begin
			grid_union <= grid_union | grid;
			if (grid[0]) begin
				seg_first <= seg;
				lit_first <= lit_first + 16'h0001;
			end
		end
	end
endmodule

// File: tb_top.sv
`timescale 1ns/100ps
module tb_top;
	localparam logic [11:0] A_CTL = vfd_pkg::VFD_OFF_CTRL;
	localparam logic [11:0] A_BNK = vfd_pkg::VFD_OFF_BANK;
	localparam logic [11:0] A_PTR = vfd_pkg::VFD_OFF_PTR;
	localparam logic [11:0] A_IND = vfd_pkg::VFD_OFF_IND;
	logic clk = 0;
	logic resetn = 0;
	logic hsel = 0;
	logic hwrite = 0;
	logic halt = 0;
	logic clr = 1;
	logic [1:0] htrans = '0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [3:0] rtc_cnt = '0;
	vfd_pkg::vfd_opt_t opts = '0;
	logic hreadyout;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [1:0] hresp;
	logic [vfd_pkg::VFD_GRIDS-1:0] grid, g_un;
	logic [vfd_pkg::VFD_SEGS-1:0] seg, s_g0;
	logic [15:0] lit;
	int mismatches = 0;
	int cmp_count = 0;
	int wd[8] = '{1, 2, 4, 10, 11, 12, 13, 14};
	always #4 clk = ~clk;
	// Slow square wave on the oscillator pin
	always @(posedge clk) rtc_cnt <= rtc_cnt + 4'h1;
	vfd_display_control vfd_display_control_inst (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .options(opts), .halt(halt),
		.rtc_osc(rtc_cnt[3]), .grid_outputs(grid), .segment_outputs(seg));
	vfd_panel vfd_panel_inst (.clk(clk), .clr(clr), .grid(grid), .seg(seg), .grid_union(g_un),
		.seg_first(s_g0), .lit_first(lit));
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Bounded wait for hready sampled high at an edge
	task automatic wt;
		for (int i = 0; i < 40; i++) begin
			@(posedge clk);
			if (hreadyout === 1'b1) return;
		end
		mismatches++;
		end_of_test;
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0_0000, a};
		wt;
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, d};
		wt;
		rd = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rc(input string n, input logic [11:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(n, {24'h00_0000, e}, rd);
	endtask
	// Settle, then sample the panel over w cycles
	task automatic meas(input int s, input int w);
		clr <= 1'b1;
		cyc(s);
		clr <= 1'b0;
		cyc(w + 1);
	endtask
	task automatic t_reset;
		rc("ctrl", A_CTL, 8'h07);
		rc("bank", A_BNK, 8'h00);
		chk("grid", 32'h0000_0000, 32'(grid));
	endtask
	task automatic t_regs;
		wr(A_CTL, 8'hFF);
		rc("ctrl", A_CTL, 8'hF7);
		rc("unmapped", 12'h100, 8'h00);
		wr(A_CTL, 8'h07);
	endtask
	task automatic t_bank;
		wr(A_PTR, 8'h40);
		wr(A_BNK, 8'h01);
		wr(A_IND, 8'hA5);
		wr(A_BNK, 8'h00);
		wr(A_IND, 8'h3C);
		rc("direct", 12'h900, 8'h3C);
		wr(12'h900, 8'h5A);
		wr(A_BNK, 8'h01);
		rc("ind disp", A_IND, 8'hA5);
		wr(A_BNK, 8'h00);
		rc("ind gen", A_IND, 8'h5A);
	endtask
	// Every mode and dimming code, one frame settle, two frames measured
	task automatic t_modes;
		logic [15:0] m;
		int f;
		wr(A_BNK, 8'h01);
		for (int k = 'h40; k <= 'h55; k++) begin
			wr(A_PTR, 8'(k));
			wr(A_IND, 8'(k) ^ 8'hC3);
		end
		for (int md = 0; md < 8; md++) begin
			wr(A_CTL, {3'(md), 2'b10, 3'(md)});
			f = (md + 4) * 64;
			m = 16'hFFFF >> (md < 3 ? 0 : md - 2);
			meas(f, 2 * f);
			chk("grids", (32'h1 << (md + 4)) - 1, 32'(g_un));
			chk("segs", 32'(16'h8283 & m), 32'(s_g0));
			chk("width", 8 * wd[md], 32'(lit));
		end
	endtask
	task automatic t_halt;
		halt <= 1'b1;
		opts <= 5'b10000;
		meas(50, 100);
		chk("halt", 32'h0, 32'(g_un));
		opts <= 5'b00001;
		meas(50, 100);
		chk("halt sys", 32'h0, 32'(g_un));
		opts <= 5'b10001;
		meas(100, 600);
		chk("halt rtc", 32'h1, 32'(|g_un));
		halt <= 1'b0;
	endtask
	// Divide by 2, 8 and 32 in mode 0, dim 0: two frames light grid 0 for 8 << d cycles
	task automatic t_div;
		wr(A_CTL, 8'h10);
		for (int d = 1; d < 7; d += 2) begin
			opts <= {1'b0, 3'(d), 1'b0};
			meas(256 << d, 512 << d);
			chk("div", 32'(8 << d), 32'(lit));
		end
		wr(A_CTL, 8'h00);
		meas(10, 200);
		chk("off", 32'h0, 32'(g_un));
	endtask
	initial begin
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_reset;
		t_regs;
		t_bank;
		t_modes;
		t_halt;
		t_div;
		end_of_test;
	end
endmodule
